//--- module_power_sequencer.sv
`include "pwrseq_map.svh"

// Overview of operation
// - Host keeps airplane request released while supply is applied to allow start.
// - Host treats power-up done only after USB link and driver are up.
// - Host detects power-off by the rail falling, not by a delay.
// - Host holds airplane request low to keep module off after shutdown.
// - Host restart pulse is low for 100 to 150 ms, then released.
// - Host uses the restart only for emergency recovery.
// - Host drives restart line open-collector only, never high.
// - Host drives no module pin high while module is off or switching.
module module_power_sequencer #(
	parameter logic [31:0] ACTIVE_CYC = 32'(`PWRSEQ_ACTIVE_MS * `PWRSEQ_CLK_KHZ),
	parameter logic [31:0] RST_CYC    = 32'(`PWRSEQ_RST_AIM_MS * `PWRSEQ_CLK_KHZ),
	parameter logic [31:0] SHUT_CYC   = 32'(`PWRSEQ_SHUT_TYP_MS * `PWRSEQ_CLK_KHZ)
) (
	input  wire logic core_clk,        // Clock, 40 MHz.
	input  wire logic rst,             // Synchronous reset, active high.
	input  wire logic clkEn,           // Clock enable; low freezes all state.
	input  wire logic supplyOn,        // Main supply is applied.
	input  wire logic ioReadyRail,     // Module ready rail level.
	input  wire logic usbReady,        // USB link up and driver loaded.
	input  wire logic shutdownReq,     // Pulse: shutdown command was sent.
	input  wire logic stayOffReq,      // Level: keep module off after shutdown.
	input  wire logic airplaneReq,     // Level: request airplane mode.
	input  wire logic restartReq,      // Pulse: emergency restart request.
	output logic      airplaneReqN_o,  // Airplane request pin output value.
	output logic      airplaneReqN_oe, // Airplane request pin drive enable.
	output logic      restartN_o,      // Restart line output value.
	output logic      restartN_oe,     // Restart line drive enable.
	output logic      hostMayAccess,   // Module accepts commands.
	output logic      moduleOff,       // Rail has fallen after shutdown.
	output logic      shutdownLate,    // Shutdown exceeds typical time.
	output logic      busy,            // Sequence in progress.
	output logic [5:0] powerState      // Current state code.
);
	// Restart pulse bounds in cycles; the aimed length is clamped into the window.
	localparam logic [31:0] RST_MIN_CYC = 32'(`PWRSEQ_RST_MIN_MS * `PWRSEQ_CLK_KHZ);
	localparam logic [31:0] RST_MAX_CYC = 32'(`PWRSEQ_RST_MAX_MS * `PWRSEQ_CLK_KHZ);
	localparam logic [31:0] RST_LEN     = (RST_CYC < RST_MIN_CYC) ? RST_MIN_CYC :
	                                      (RST_CYC > RST_MAX_CYC) ? RST_MAX_CYC : RST_CYC;

	// Sequence state, time in state and the host-side latches.
	pwrseq_pkg::pwr_state_t state_ff;
	pwrseq_pkg::pwr_state_t nxt_state;
	logic [`PWRSEQ_CNT_W-1:0] cnt_ff;
	logic [`PWRSEQ_CNT_W-1:0] nxt_cnt;
	logic                     stayOff_ff;
	logic                     nxt_stayOff;
	logic                     late_ff;
	logic                     nxt_late;
	logic                     off_ff;
	logic                     nxt_off;
	logic                     railUp;

	// Filtered view of the ready rail.
	rail_filter u_rail_filter (
		.core_clk   (core_clk),
		.rst        (rst),
		.clkEn      (clkEn),
		.rawLevel   (ioReadyRail),
		.cleanLevel (railUp)
	);

	// Counts time in the current state (saturating).
	function automatic logic [`PWRSEQ_CNT_W-1:0] bump(input logic [`PWRSEQ_CNT_W-1:0] c);
		bump = (c == '1) ? c : c + 1'b1;
	endfunction

	// Tells whether the sequencer sits in one given state.
	function automatic logic stateIs(input logic [5:0] s, input logic [5:0] want);
		stateIs = (s == want);
	endfunction

	// Next-state logic of the power sequence.
	always_comb
	begin
		// Everything holds by default while the time counter runs on.
		nxt_state   = state_ff;
		nxt_cnt     = bump(cnt_ff);
		nxt_stayOff = stayOff_ff;
		nxt_late    = late_ff;
		nxt_off     = off_ff;
		// An emergency restart overrides every state but a restart already running.
		if (restartReq && !stateIs(state_ff, pwrseq_pkg::ST_RESTART))
		begin
			nxt_state = pwrseq_pkg::ST_RESTART;
			nxt_cnt   = '0;
			nxt_off   = 1'b0;
		end
		else
		begin
			unique case (state_ff)
				pwrseq_pkg::ST_OFF:
				begin
					// Start only with the supply up and the stay-off latch clear.
					if (supplyOn && !stayOff_ff)
					begin
						nxt_state = pwrseq_pkg::ST_INIT;
						nxt_cnt   = '0;
						nxt_off   = 1'b0;
					end
				end
				pwrseq_pkg::ST_INIT:
				begin
					// Supply loss drops back to off; otherwise wait for time and rail.
					if (!supplyOn)
						nxt_state = pwrseq_pkg::ST_OFF;
					else if (cnt_ff >= ACTIVE_CYC && railUp)
						nxt_state = pwrseq_pkg::ST_WAITLINK;
				end
				pwrseq_pkg::ST_WAITLINK:
				begin
					// Access opens only after the USB link reports ready.
					if (!supplyOn)
						nxt_state = pwrseq_pkg::ST_OFF;
					else if (usbReady)
						nxt_state = pwrseq_pkg::ST_ACTIVE;
				end
				pwrseq_pkg::ST_ACTIVE:
				begin
					// A shutdown latches whether the module must be kept off afterwards.
					if (!supplyOn)
						nxt_state = pwrseq_pkg::ST_OFF;
					else if (shutdownReq)
					begin
						nxt_state   = pwrseq_pkg::ST_FINAL;
						nxt_cnt     = '0;
						nxt_late    = 1'b0;
						nxt_stayOff = stayOffReq;
					end
				end
				pwrseq_pkg::ST_FINAL:
				begin
					// No timeout: only the falling rail, a supply loss or a restart request ends finalization.
					// The late flag only warns; it never moves the state on.
					if (cnt_ff >= SHUT_CYC)
						nxt_late = 1'b1;
					if (!railUp || !supplyOn)
					begin
						nxt_state = pwrseq_pkg::ST_OFF;
						nxt_off   = 1'b1;
						// Without stay-off the counter restarts for the next boot.
						if (!stayOff_ff)
							nxt_cnt = '0;
					end
				end
				pwrseq_pkg::ST_RESTART:
				begin
					// Hold the line low for the pulse length, then release.
					if (cnt_ff >= RST_LEN - 32'h0000_0001)
					begin
						nxt_state   = pwrseq_pkg::ST_INIT;
						nxt_cnt     = '0;
						nxt_stayOff = 1'b0;
					end
				end
				// An illegal code falls back to off.
				default:
				begin
					nxt_state = pwrseq_pkg::ST_OFF;
					nxt_cnt   = '0;
				end
			endcase
		end
		// While off, the stay-off latch follows the host's release of its request.
		if (stateIs(state_ff, pwrseq_pkg::ST_OFF) && !stayOffReq)
			nxt_stayOff = 1'b0;
	end

	// Registers the sequence state.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state_ff   <= pwrseq_pkg::ST_OFF;
			cnt_ff     <= '0;
			stayOff_ff <= 1'b0;
			late_ff    <= 1'b0;
			off_ff     <= 1'b0;
		end
		// A low clock enable freezes every register.
		else if (clkEn)
		begin
			state_ff   <= nxt_state;
			cnt_ff     <= nxt_cnt;
			stayOff_ff <= nxt_stayOff;
			late_ff    <= nxt_late;
			off_ff     <= nxt_off;
		end
	end

	// Airplane pin: pulled low to request airplane or to keep the module off.
	// Otherwise released so the pin floats to normal mode without driving high.
	// The stay-off latch keeps it low so the module stays down after shutdown.
	assign airplaneReqN_o  = 1'b0;
	assign airplaneReqN_oe = airplaneReq || stayOff_ff;

	// Restart line: open-collector, only ever pulled low.
	assign restartN_o  = 1'b0;
	assign restartN_oe = stateIs(state_ff, pwrseq_pkg::ST_RESTART);

	// Access is granted only in the active state.
	assign hostMayAccess = stateIs(state_ff, pwrseq_pkg::ST_ACTIVE);

	// Busy covers every state in which a sequence is still running.
	assign busy          = stateIs(state_ff, pwrseq_pkg::ST_INIT)
	                    || stateIs(state_ff, pwrseq_pkg::ST_WAITLINK)
	                    || stateIs(state_ff, pwrseq_pkg::ST_FINAL)
	                    || stateIs(state_ff, pwrseq_pkg::ST_RESTART);

	// Registered status flags and the state code.
	assign moduleOff     = off_ff;
	assign shutdownLate  = late_ff;
	assign powerState    = state_ff;
endmodule

//--- pwrseq_map.svh
`ifndef PWRSEQ_MAP_SVH
`define PWRSEQ_MAP_SVH

// Clock rate in kHz, so that millisecond figures convert without overflow.
`define PWRSEQ_CLK_KHZ        32'd40000
// Least time from supply on to active service, in ms.
`define PWRSEQ_ACTIVE_MS      32'd15000
// Restart pulse window, in ms.
`define PWRSEQ_RST_MIN_MS     32'd100
`define PWRSEQ_RST_MAX_MS     32'd150
// Pulse length aimed at, midway in the window, in ms.
`define PWRSEQ_RST_AIM_MS     32'd125
// Typical shutdown time, in ms; used only as a late-shutdown warning.
`define PWRSEQ_SHUT_TYP_MS    32'd12000
// Rail filter length in cycles.
`define PWRSEQ_FILT_CYC       4'h8
// Width of the time counter.
`define PWRSEQ_CNT_W          32

`endif

//--- pwrseq_pkg.sv
package pwrseq_pkg;
	// Host view of the module's power state, one-hot.
	typedef enum logic [5:0] {
		ST_OFF      = 6'h01,
		ST_INIT     = 6'h02,
		ST_WAITLINK = 6'h04,
		ST_ACTIVE   = 6'h08,
		ST_FINAL    = 6'h10,
		ST_RESTART  = 6'h20
	} pwr_state_t;
endpackage

//--- rail_filter.sv
`include "pwrseq_map.svh"

// Debounces the ready rail: the output changes only after a stable run.
module rail_filter (
	input  wire logic core_clk,  // Clock.
	input  wire logic rst,       // Synchronous reset, active high.
	input  wire logic clkEn,     // Clock enable.
	input  wire logic rawLevel,  // Rail level as sampled.
	output logic      cleanLevel // Filtered rail level.
);
	logic [3:0] runCnt_ff;
	logic [3:0] nxt_runCnt;
	logic       level_ff;
	logic       nxt_level;

	// Counts agreeing samples and adopts the new level after a full run.
	always_comb
	begin
		nxt_runCnt = 4'h0;
		nxt_level  = level_ff;
		if (rawLevel != level_ff)
		begin
			nxt_runCnt = runCnt_ff + 4'h1;
			if (nxt_runCnt == `PWRSEQ_FILT_CYC)
			begin
				nxt_level  = rawLevel;
				nxt_runCnt = 4'h0;
			end
		end
	end

	// Registers the filter state.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			runCnt_ff <= 4'h0;
			level_ff  <= 1'b0;
		end
		else if (clkEn)
		begin
			runCnt_ff <= nxt_runCnt;
			level_ff  <= nxt_level;
		end
	end

	assign cleanLevel = level_ff;
endmodule

//--- pwrseq_assertions.sv
module pwrseq_assertions (
	input wire logic       core_clk,        // Clock.
	input wire logic       rst,             // Reset.
	input wire logic       clkEn,           // Enable.
	input wire logic       supplyOn,        // Supply.
	input wire logic       ioReadyRail,     // Rail.
	input wire logic       usbReady,        // Link.
	input wire logic       shutdownReq,     // Shutdown.
	input wire logic       airplaneReq,     // Airplane.
	input wire logic       restartReq,      // Restart.
	input wire logic       airplaneReqN_o,  // Pin value.
	input wire logic       airplaneReqN_oe, // Pin enable.
	input wire logic       restartN_o,      // Pin value.
	input wire logic       restartN_oe,     // Pin enable.
	input wire logic       hostMayAccess,   // Access.
	input wire logic       moduleOff,       // Off flag.
	input wire logic       busy,            // Busy.
	input wire logic [5:0] powerState       // State.
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	// Eight enabled cycles of a fallen rail while finalizing.
	sequence railGone;
		(powerState == 6'h10 && clkEn && supplyOn && !restartReq && !ioReadyRail)[*8];
	endsequence
	// The restart state is entered from any other state.
	sequence restartBegins;
		(powerState != 6'h20) ##1 (powerState == 6'h20);
	endsequence
	// Each property but a_pins_low_only ties an output to its cause.
	a_pins_low_only: assert property (!airplaneReqN_o && !restartN_o)
		else $error("Open-drain pin driven high.");
	a_access_map: assert property (hostMayAccess == (powerState == 6'h08))
		else $error("Access flag wrong.");
	a_busy_map: assert property (busy == (powerState inside {6'h02, 6'h04, 6'h10, 6'h20}))
		else $error("Busy flag wrong.");
	a_restart_pin: assert property (restartN_oe == (powerState == 6'h20))
		else $error("Restart pin wrong.");
	a_start_up: assert property ((powerState == 6'h01 && clkEn && supplyOn
		&& !airplaneReqN_oe && !restartReq) |=> powerState == 6'h02)
		else $error("No start on supply.");
	a_restart_entry: assert property ((clkEn && restartReq && powerState != 6'h20)
		|=> powerState == 6'h20)
		else $error("Restart not taken.");
	a_restart_cause: assert property (restartBegins |-> $past(restartReq))
		else $error("Restart without request.");
	a_shut_entry: assert property ((clkEn && shutdownReq && powerState == 6'h08
		&& supplyOn && !restartReq) |=> (powerState == 6'h10 && !hostMayAccess))
		else $error("Shutdown not taken.");
	a_link_first: assert property ((clkEn && powerState == 6'h04 && !usbReady)
		|=> powerState != 6'h08)
		else $error("Active before link.");
	a_airplane_pin: assert property (airplaneReq |-> airplaneReqN_oe)
		else $error("Airplane pin not pulled.");
	a_rail_ends: assert property (railGone |-> ##[1:3] (powerState == 6'h01 && moduleOff))
		else $error("Rail fall not seen.");
endmodule

//--- pwr_device_model.sv
module pwr_device_model #(
	parameter int INIT_CYC = 210, // Boot time.
	parameter int FIN_CYC  = 350, // Finalization time.
	parameter int LINK_CYC = 150  // Link delay after the rail rises.
) (
	input  wire logic core_clk,    // Clock.
	input  wire logic supplyOn,    // Supply.
	input  wire logic airplaneN,   // Airplane pin level.
	input  wire logic restartN,    // Restart line level.
	input  wire logic shutdownCmd, // Shutdown command.
	output logic      ioReadyRail, // Ready rail.
	output logic      usbReady     // Link up.
);
	timeunit 1ns;
	timeprecision 100ps;
	int unsigned cnt = 0;
	logic [1:0]  st  = 2'h0;
	// Walks off, boot, on and finalization; a low restart line reboots.
	always @(posedge core_clk)
	begin
		cnt <= cnt + 1;
		if (!supplyOn)
			st <= 2'h0;
		else if (!restartN)
		begin
			st <= 2'h1;
			cnt <= 0;
		end
		else if (st == 2'h0 && airplaneN)
		begin
			st <= 2'h1;
			cnt <= 0;
		end
		else if ((st == 2'h1 && cnt >= INIT_CYC) || (st == 2'h3 && cnt >= FIN_CYC))
		begin
			st <= st + 2'h1;
			cnt <= 0;
		end
		else if (st == 2'h2 && shutdownCmd)
		begin
			st <= 2'h3;
			cnt <= 0;
		end
	end
	// Rail rises after boot, link later; no access outside the on state.
	assign ioReadyRail = st[1];
	assign usbReady = st == 2'h2 && cnt >= LINK_CYC;
endmodule

//--- module_power_sequencer_tb.sv
module module_power_sequencer_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic       core_clk = 1'b0;
	logic       rst = 1'b1;
	logic       clkEn = 1'b1;
	logic       supplyOn = 1'b0;
	logic       shutdownReq = 1'b0;
	logic       stayOffReq = 1'b0;
	logic       airplaneReq = 1'b0;
	logic       restartReq = 1'b0;
	logic       ioReadyRail, usbReady, apO, apOe, rsO, rsOe, hostMayAccess, moduleOff;
	logic       shutdownLate, busy;
	logic [5:0] powerState;
	int         badCount = 0;
	int         compares = 0;
	int         n;
	// Clock of 25 ns.
	always #12.5 core_clk = ~core_clk;
	module_power_sequencer #(.ACTIVE_CYC(32'd200), .SHUT_CYC(32'd300)) uut (.core_clk(core_clk),
		.rst(rst), .clkEn(clkEn), .supplyOn(supplyOn), .ioReadyRail(ioReadyRail),
		.usbReady(usbReady), .shutdownReq(shutdownReq), .stayOffReq(stayOffReq),
		.airplaneReq(airplaneReq), .restartReq(restartReq), .airplaneReqN_o(apO),
		.airplaneReqN_oe(apOe), .restartN_o(rsO), .restartN_oe(rsOe), .busy(busy),
		.hostMayAccess(hostMayAccess), .moduleOff(moduleOff), .shutdownLate(shutdownLate),
		.powerState(powerState));
	// Partner module; its rail rises before the least boot time, so that gate is exercised.
	pwr_device_model #(.INIT_CYC(100)) dev (.core_clk(core_clk), .supplyOn(supplyOn),
		.airplaneN(apOe ? apO : 1'b1),
		.restartN(rsOe ? rsO : 1'b1), .shutdownCmd(shutdownReq), .ioReadyRail(ioReadyRail),
		.usbReady(usbReady));
	task automatic tally_and_finish();
		if (badCount == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			badCount++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	task automatic wait_state(input logic [5:0] s);
		n = 0;
		while (powerState !== s && n < 3000)
		begin
			step(1);
			n++;
		end
		chk(powerState, s);
	endtask
	// Start on supply, refuse early shutdown, go active after the link.
	task automatic t_powerup();
		supplyOn = 1'b1;
		step(1);
		shutdownReq = 1'b1;
		step(1);
		shutdownReq = 1'b0;
		chk({busy, hostMayAccess, powerState}, 8'h82);
		wait_state(6'h04);
		chk(8'(n >= 198), 8'h01);
		chk({ioReadyRail, usbReady, hostMayAccess}, 8'h04);
		wait_state(6'h08);
		chk({busy, hostMayAccess, usbReady}, 8'h03);
	endtask
	// Shut down, watch the late flag and the rail, optionally stay off.
	task automatic t_shutdown(input logic stay);
		stayOffReq = stay;
		shutdownReq = 1'b1;
		step(1);
		shutdownReq = 1'b0;
		chk({busy, hostMayAccess, powerState}, 8'h90);
		step(100);
		chk({shutdownLate, powerState}, 8'h10);
		step(220);
		chk({shutdownLate, powerState}, 8'h50);
		wait_state(6'h01);
		chk({moduleOff, ioReadyRail}, 8'h02);
		step(20);
		chk({apOe, powerState}, stay ? 8'h41 : 8'h02);
		stayOffReq = 1'b0;
		wait_state(6'h08);
	endtask
	// Restart pulls the line, ignores the request held high through it, ends with reset.
	task automatic t_restart();
		restartReq = 1'b1;
		step(1);
		chk({rsOe, rsO, powerState}, 8'hA0);
		step(1000);
		restartReq = 1'b0;
		chk({rsOe, rsO, powerState}, 8'hA0);
		rst = 1'b1;
		step(1);
		rst = 1'b0;
		chk({rsOe, powerState}, 8'h01);
	endtask
	// Main sequence.
	initial
	begin
		step(10);
		rst = 1'b0;
		t_powerup();
		airplaneReq = 1'b1;
		step(1);
		chk({apOe, apO}, 8'h02);
		airplaneReq = 1'b0;
		clkEn = 1'b0;
		shutdownReq = 1'b1;
		step(3);
		shutdownReq = 1'b0;
		clkEn = 1'b1;
		step(1);
		chk({apOe, powerState}, 8'h08);
		t_shutdown(1'b0);
		t_shutdown(1'b1);
		t_restart();
		tally_and_finish();
	end
	// Watchdog.
	initial
	begin
		repeat (20000) @(posedge core_clk);
		badCount++;
		tally_and_finish();
	end
endmodule
bind module_power_sequencer pwrseq_assertions chk_i (.core_clk(core_clk), .rst(rst),
	.clkEn(clkEn), .supplyOn(supplyOn), .ioReadyRail(ioReadyRail), .usbReady(usbReady),
	.shutdownReq(shutdownReq), .airplaneReq(airplaneReq), .restartReq(restartReq),
	.airplaneReqN_o(airplaneReqN_o), .airplaneReqN_oe(airplaneReqN_oe), .busy(busy),
	.restartN_o(restartN_o), .restartN_oe(restartN_oe), .hostMayAccess(hostMayAccess),
	.moduleOff(moduleOff), .powerState(powerState));
